/* rtl/fogf_pkg.sv */
package fogf_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] FOGF_ADDR_SCALING = 4'h6;
  localparam logic [3:0] FOGF_ADDR_FORMAT  = 4'h7;
  localparam logic [3:0] FOGF_ADDR_STATUS  = 4'hd;
  localparam logic [3:0] FOGF_ADDR_MASK    = 4'he;

  // Scaling control fields
  localparam int FOGF_FRAC_LSB  = 0;
  localparam int FOGF_EXP_LSB   = 4;
  localparam int FOGF_ROUND_LSB = 8;
  localparam logic [15:0] FOGF_SCALING_WMASK = 16'h7fff;
  localparam logic [15:0] FOGF_SCALING_RESET = 16'h0000;

  // Result format fields
  localparam int FOGF_INV_LSB   = 0;
  localparam int FOGF_WIDE_BIT  = 2;
  localparam int FOGF_SPLIT_BIT = 3;
  localparam int FOGF_MUX_LSB   = 4;
  localparam int FOGF_SUM_BIT   = 6;
  localparam int FOGF_VPOL_BIT  = 7;
  localparam logic [15:0] FOGF_FORMAT_WMASK = 16'h00ff;
  localparam logic [15:0] FOGF_FORMAT_RESET = 16'h0000;

  // Event status / mask layout
  localparam int FOGF_EV_OVF_A = 0;
  localparam int FOGF_EV_OVF_B = 1;
  localparam logic [1:0] FOGF_EV_RESET = 2'h0;

  // Rounding codes, one-hot
  localparam logic [6:0] FOGF_RND_8  = 7'h01;
  localparam logic [6:0] FOGF_RND_10 = 7'h02;
  localparam logic [6:0] FOGF_RND_12 = 7'h04;
  localparam logic [6:0] FOGF_RND_14 = 7'h08;
  localparam logic [6:0] FOGF_RND_16 = 7'h10;
  localparam logic [6:0] FOGF_RND_20 = 7'h20;
  localparam logic [6:0] FOGF_RND_24 = 7'h40;

  // Mantissa is (16 + F) / 16, input MSB lands on output MSB at unity
  localparam logic [4:0] FOGF_MANT_ONE = 5'h10;
  localparam int         FOGF_POST_SHIFT = 4;

  localparam logic [31:0] FOGF_POS_FULL = 32'h7fffffff;
  localparam logic [31:0] FOGF_NEG_FULL = 32'h80000000;

  typedef enum logic [1:0] {
    FOGF_INV_OFF,
    FOGF_INV_FULL,
    FOGF_INV_HALF,
    FOGF_INV_QUARTER
  } fogf_inv_e;

  localparam logic [1:0] FOGF_MUX_OFF     = 2'h0;
  localparam logic [1:0] FOGF_MUX_HALF    = 2'h1;
  localparam logic [1:0] FOGF_MUX_QUARTER = 2'h3;
  localparam logic [1:0] FOGF_MUX_GAP_HALF    = 2'h1;
  localparam logic [1:0] FOGF_MUX_GAP_QUARTER = 2'h2;

  typedef struct packed {
    logic [31:0] a;
    logic [31:0] b;
  } fogf_sample_s;

  typedef struct packed {
    logic [31:0] val;
    logic        ovf;
  } fogf_scaled_s;

  typedef struct packed {
    logic [15:0] scaling;
    logic [15:0] format;
  } fogf_cfg_s;

endpackage

/* rtl/fogf_output_stage.sv */
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Fraction in bits 0-3, exponent 4-7
// - Gain is 2^S(1+F/16) times coefficient sum
// - Unity gain maps input MSB to output MSB
// - New gain applies only at sample boundary
// - One gain setting serves both paths
// - One-hot rounding code selects MSB count
// - Round each 32-bit result to chosen MSBs
// - Overflow clamps to signed full scale
// - Each path raises its own overflow pin
// - Inversion field selects sample rate to negate
// - Negate even A samples, odd B samples
// - Wide split: upper 16 on A, low 8 on B
// - Multiplex both paths on A, clear B
// - A sample precedes B in multiplex
// - Path sum appears on B unless split or multiplexed
// - Format bit 7 inverts valid strobe level
module fogf_output_stage (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire fogf_pkg::fogf_sample_s path_result,
  input  wire logic                  result_valid,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [15:0]           reg_rdata,
  output logic      [15:0]           out_a,
  output logic      [15:0]           out_b,
  output logic                       valid_strobe,
  output logic                       path_a_overflow_pin,
  output logic                       path_b_overflow_pin,
  output logic                       irq
);

  // Number of low bits cleared for a rounding code; 0 means truncate
  function automatic logic [5:0] fogf_clear_bits(input logic [6:0] code);
    logic [5:0] n;
    n = 6'h00;
    case (code)
      fogf_pkg::FOGF_RND_8:  n = 6'h18;
      fogf_pkg::FOGF_RND_10: n = 6'h16;
      fogf_pkg::FOGF_RND_12: n = 6'h14;
      fogf_pkg::FOGF_RND_14: n = 6'h12;
      fogf_pkg::FOGF_RND_16: n = 6'h10;
      fogf_pkg::FOGF_RND_20: n = 6'h0c;
      fogf_pkg::FOGF_RND_24: n = 6'h08;
      default:               n = 6'h00;
    endcase
    return n;
  endfunction

  function automatic logic [31:0] fogf_clamp(input logic sign_neg);
    return sign_neg ? fogf_pkg::FOGF_NEG_FULL : fogf_pkg::FOGF_POS_FULL;
  endfunction

  // Scale, round and saturate one path; shared by both paths
  function automatic fogf_pkg::fogf_scaled_s fogf_scale(input logic [31:0] x,
                                                         input logic [15:0] cfg);
    logic signed [51:0] xe;
    logic signed [51:0] mant;
    logic signed [51:0] p;
    logic        [51:0] half;
    logic        [51:0] keep;
    logic        [51:0] r;
    logic        [5:0]  nclr;
    fogf_pkg::fogf_scaled_s res;
    xe   = $signed({{20{x[31]}}, x});
    mant = $signed({47'h0, fogf_pkg::FOGF_MANT_ONE | {1'b0, cfg[fogf_pkg::FOGF_FRAC_LSB +: 4]}});
    p    = xe * mant;
    p    = (p <<< cfg[fogf_pkg::FOGF_EXP_LSB +: 4]) >>> fogf_pkg::FOGF_POST_SHIFT;
    nclr = fogf_clear_bits(cfg[fogf_pkg::FOGF_ROUND_LSB +: 7]);
    half = (nclr == 6'h00) ? 52'h0 : (52'h1 << (nclr - 6'h01));
    keep = ~((52'h1 << nclr) - 52'h1);
    r    = (52'(p) + half) & keep;
    res.ovf = (r[51:31] != {21{1'b0}}) && (r[51:31] != {21{1'b1}});
    res.val = res.ovf ? fogf_clamp(r[51]) : r[31:0];
    return res;
  endfunction

  // Negation that cannot wrap at negative full scale
  function automatic logic [31:0] fogf_negate(input logic [31:0] x);
    return (x == fogf_pkg::FOGF_NEG_FULL) ? fogf_pkg::FOGF_POS_FULL : (32'h0 - x);
  endfunction

  // Register file
  logic [15:0] scaling_reg;
  logic [15:0] format_reg;
  logic [1:0]  status_reg;
  logic [1:0]  status_next;
  logic [1:0]  mask_reg;
  logic [15:0] rdata_next;
  logic [1:0]  ev_set;

  wire wr_scaling = reg_wr && (reg_addr == fogf_pkg::FOGF_ADDR_SCALING);
  wire wr_format  = reg_wr && (reg_addr == fogf_pkg::FOGF_ADDR_FORMAT);
  wire wr_mask    = reg_wr && (reg_addr == fogf_pkg::FOGF_ADDR_MASK);
  wire rd_status  = reg_rd && (reg_addr == fogf_pkg::FOGF_ADDR_STATUS);

  assign rdata_next =
      !reg_rd                                    ? 16'h0000 :
      (reg_addr == fogf_pkg::FOGF_ADDR_SCALING)  ? scaling_reg :
      (reg_addr == fogf_pkg::FOGF_ADDR_FORMAT)   ? format_reg :
      (reg_addr == fogf_pkg::FOGF_ADDR_STATUS)   ? {14'h0, status_reg} :
      (reg_addr == fogf_pkg::FOGF_ADDR_MASK)     ? {14'h0, mask_reg} : 16'h0000;

  // Set wins over the clear caused by a status read
  assign status_next = (rd_status ? 2'h0 : status_reg) | ev_set;

  always_ff @(posedge clk) begin
    if (reset) begin
      scaling_reg <= fogf_pkg::FOGF_SCALING_RESET;
      format_reg  <= fogf_pkg::FOGF_FORMAT_RESET;
      status_reg  <= fogf_pkg::FOGF_EV_RESET;
      mask_reg    <= fogf_pkg::FOGF_EV_RESET;
      reg_rdata   <= 16'h0000;
      irq         <= 1'b0;
    end else begin
      if (wr_scaling) scaling_reg <= reg_wdata & fogf_pkg::FOGF_SCALING_WMASK;
      if (wr_format)  format_reg  <= reg_wdata & fogf_pkg::FOGF_FORMAT_WMASK;
      if (wr_mask)    mask_reg    <= reg_wdata[1:0];
      status_reg <= status_next;
      reg_rdata  <= rdata_next;
      irq        <= |(status_next & mask_reg);
    end
  end

  // Stage 1: settings captured with the sample, so a write never splits one
  logic [2:0]  phase_reg;
  logic        s1_valid_reg;
  logic [2:0]  s1_phase_reg;
  fogf_pkg::fogf_cfg_s    s1_cfg_reg;
  fogf_pkg::fogf_scaled_s s1_a_reg;
  fogf_pkg::fogf_scaled_s s1_b_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      phase_reg    <= 3'h0;
      s1_valid_reg <= 1'b0;
      s1_phase_reg <= 3'h0;
      s1_cfg_reg   <= '0;
      s1_a_reg     <= '0;
      s1_b_reg     <= '0;
    end else begin
      phase_reg    <= phase_reg + 3'h1;
      s1_valid_reg <= result_valid;
      if (result_valid) begin
        s1_cfg_reg   <= '{scaling: scaling_reg, format: format_reg};
        s1_phase_reg <= phase_reg;
        s1_a_reg     <= fogf_scale(path_result.a, scaling_reg);
        s1_b_reg     <= fogf_scale(path_result.b, scaling_reg);
      end
    end
  end

  // Stage 2: negation, summing and pin formatting
  wire [15:0] fmt = s1_cfg_reg.format;
  wire [1:0]  inv_sel = fmt[fogf_pkg::FOGF_INV_LSB +: 2];
  wire [1:0]  mux_sel = fmt[fogf_pkg::FOGF_MUX_LSB +: 2];
  wire        split_on = fmt[fogf_pkg::FOGF_SPLIT_BIT];
  wire        sum_on   = fmt[fogf_pkg::FOGF_SUM_BIT] | fmt[fogf_pkg::FOGF_WIDE_BIT];
  wire        mux_on   = (mux_sel != fogf_pkg::FOGF_MUX_OFF);

  logic odd_time;
  always_comb begin
    case (fogf_pkg::fogf_inv_e'(inv_sel))
      fogf_pkg::FOGF_INV_FULL:    odd_time = s1_phase_reg[0];
      fogf_pkg::FOGF_INV_HALF:    odd_time = s1_phase_reg[1];
      fogf_pkg::FOGF_INV_QUARTER: odd_time = s1_phase_reg[2];
      default:                    odd_time = 1'b0;
    endcase
  end

  wire inv_on = (inv_sel != 2'h0);
  wire [31:0] a_fin = (inv_on && !odd_time) ? fogf_negate(s1_a_reg.val) : s1_a_reg.val;
  wire [31:0] b_fin = (inv_on &&  odd_time) ? fogf_negate(s1_b_reg.val) : s1_b_reg.val;

  wire [32:0] sum_raw = {a_fin[31], a_fin} + {b_fin[31], b_fin};
  wire        sum_ovf = (sum_raw[32] != sum_raw[31]);
  wire [31:0] sum_val = sum_ovf ? fogf_clamp(sum_raw[32]) : sum_raw[31:0];
  wire [31:0] b_word  = sum_on ? sum_val : b_fin;

  // Pending B word while multiplexing
  logic [15:0] pend_reg;
  logic        pend_ovf_reg;
  logic [1:0]  pend_cnt_reg;
  wire         pend_fire = (pend_cnt_reg == 2'h1);

  logic [15:0] a_next;
  logic [15:0] b_next;
  logic        v_next;
  logic        oa_next;
  logic        ob_next;

  always_comb begin
    a_next  = 16'h0000;
    b_next  = 16'h0000;
    v_next  = 1'b0;
    oa_next = 1'b0;
    ob_next = 1'b0;
    if (s1_valid_reg) begin
      v_next  = 1'b1;
      oa_next = s1_a_reg.ovf;
      if (split_on) begin
        a_next  = b_word[31:16];
        b_next  = {b_word[15:8], 8'h00};
        ob_next = s1_b_reg.ovf;
      end else if (mux_on) begin
        a_next  = a_fin[31:16];
      end else begin
        a_next  = a_fin[31:16];
        b_next  = b_word[31:16];
        ob_next = s1_b_reg.ovf;
      end
    end else if (pend_fire) begin
      v_next  = 1'b1;
      a_next  = pend_reg;
      ob_next = pend_ovf_reg;
    end
  end

  logic out_valid_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      pend_reg            <= 16'h0000;
      pend_ovf_reg        <= 1'b0;
      pend_cnt_reg        <= 2'h0;
      out_a               <= 16'h0000;
      out_b               <= 16'h0000;
      out_valid_reg       <= 1'b0;
      valid_strobe        <= 1'b0;
      path_a_overflow_pin <= 1'b0;
      path_b_overflow_pin <= 1'b0;
    end else begin
      if (s1_valid_reg && mux_on && !split_on) begin
        pend_reg     <= b_word[31:16];
        pend_ovf_reg <= s1_b_reg.ovf;
        pend_cnt_reg <= (mux_sel == fogf_pkg::FOGF_MUX_HALF) ?
                        fogf_pkg::FOGF_MUX_GAP_HALF : fogf_pkg::FOGF_MUX_GAP_QUARTER;
      end else if (pend_cnt_reg != 2'h0) begin
        pend_cnt_reg <= pend_cnt_reg - 2'h1;
      end
      out_a               <= a_next;
      out_b               <= b_next;
      out_valid_reg       <= v_next;
      valid_strobe        <= v_next ^ fmt[fogf_pkg::FOGF_VPOL_BIT];
      path_a_overflow_pin <= oa_next;
      path_b_overflow_pin <= ob_next;
    end
  end

  assign ev_set[fogf_pkg::FOGF_EV_OVF_A] = oa_next;
  assign ev_set[fogf_pkg::FOGF_EV_OVF_B] = ob_next;

  // Checks
  property p_fields_stored;
    @(posedge clk) disable iff (reset)
      wr_scaling |=> scaling_reg[7:0] == $past(reg_wdata[7:0]);
  endproperty
  a_fields_stored: assert property (p_fields_stored) else $error("gain fields not stored");

  property p_cfg_at_sample;
    @(posedge clk) disable iff (reset)
      !result_valid |=> $stable(s1_cfg_reg);
  endproperty
  a_cfg_at_sample: assert property (p_cfg_at_sample) else $error("setting changed mid sample");

  property p_clamp;
    @(posedge clk) disable iff (reset)
      s1_valid_reg && s1_a_reg.ovf |->
        (s1_a_reg.val == fogf_pkg::FOGF_POS_FULL) || (s1_a_reg.val == fogf_pkg::FOGF_NEG_FULL);
  endproperty
  a_clamp: assert property (p_clamp) else $error("overflow not clamped");

  property p_ovf_aligned;
    @(posedge clk) disable iff (reset)
      s1_valid_reg |=> path_a_overflow_pin == $past(s1_a_reg.ovf) && out_valid_reg;
  endproperty
  a_ovf_aligned: assert property (p_ovf_aligned) else $error("overflow pin misaligned");

  property p_mux_b_clear;
    @(posedge clk) disable iff (reset)
      s1_valid_reg && mux_on && !split_on |=> out_b == 16'h0000;
  endproperty
  a_mux_b_clear: assert property (p_mux_b_clear) else $error("B pins not cleared in mux");

  sequence s_mux_half_a;
    s1_valid_reg && mux_sel == fogf_pkg::FOGF_MUX_HALF && !split_on;
  endsequence
  property p_mux_order;
    @(posedge clk) disable iff (reset)
      s_mux_half_a |=> out_a == $past(a_fin[31:16]) ##1 (out_valid_reg && out_a == $past(pend_reg));
  endproperty
  a_mux_order: assert property (p_mux_order) else $error("mux order wrong");

  property p_split_low;
    @(posedge clk) disable iff (reset)
      s1_valid_reg && split_on |=> out_b[7:0] == 8'h00 && out_a == $past(b_word[31:16]);
  endproperty
  a_split_low: assert property (p_split_low) else $error("split layout wrong");

  property p_strobe_pol;
    @(posedge clk) disable iff (reset)
      ##1 valid_strobe == (out_valid_reg ^ $past(fmt[fogf_pkg::FOGF_VPOL_BIT]));
  endproperty
  a_strobe_pol: assert property (p_strobe_pol) else $error("valid strobe polarity");

  property p_sum_on_b;
    @(posedge clk) disable iff (reset)
      s1_valid_reg && fmt[fogf_pkg::FOGF_SUM_BIT] && !split_on && !mux_on
        |=> out_b == $past(sum_val[31:16]);
  endproperty
  a_sum_on_b: assert property (p_sum_on_b) else $error("sum not on B pins");

endmodule

`default_nettype wire

/* dv/fogf_sink_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Downstream receiver: no back-pressure, keeps each word at its active level
module fogf_sink_model (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [15:0] out_a,
  input wire logic [15:0] out_b,
  input wire logic        valid_strobe,
  input wire logic        path_a_overflow_pin,
  input wire logic        path_b_overflow_pin,
  input wire logic        strobe_low
);
  logic [33:0] got[$];
  int          stray = 0;

  always @(posedge clk) begin
    if (!reset && (valid_strobe ^ strobe_low)) begin
      got.push_back({out_a, out_b, path_a_overflow_pin, path_b_overflow_pin});
    end else if (!reset && (path_a_overflow_pin || path_b_overflow_pin)) begin
      stray++;
    end
  end
endmodule

`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic                   clk = 1'b0;
  logic                   reset = 1'b1;
  fogf_pkg::fogf_sample_s path_result = '0;
  logic                   result_valid = 1'b0;
  logic [3:0]             reg_addr = 4'h0;
  logic [15:0]            reg_wdata = 16'h0000;
  logic                   reg_wr = 1'b0;
  logic                   reg_rd = 1'b0;
  logic [15:0]            reg_rdata, out_a, out_b, rv;
  logic                   valid_strobe, ova, ovb, irq;
  logic                   strobe_low = 1'b0;
  logic [1:0]             ev_exp = 2'h0;
  logic [33:0]            exp_q[$];
  int                     mismatches = 0;
  int                     comparisons = 0;
  int                     cycles = 0;
  localparam logic [6:0]  rnd_codes [8] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40};
  // Wide precision entry also sets sum and split, as software must
  localparam logic [7:0]  fmts [9] = '{8'h01, 8'h02, 8'h03, 8'h08, 8'h40, 8'h4c, 8'h10, 8'h30, 8'h80};

  always #5 clk = ~clk;

  fogf_output_stage dut_u (.clk(clk), .reset(reset), .path_result(path_result),
    .result_valid(result_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_a(out_a), .out_b(out_b),
    .valid_strobe(valid_strobe), .path_a_overflow_pin(ova), .path_b_overflow_pin(ovb), .irq(irq));

  fogf_sink_model sink_u (.clk(clk), .reset(reset), .out_a(out_a), .out_b(out_b),
    .valid_strobe(valid_strobe), .path_a_overflow_pin(ova), .path_b_overflow_pin(ovb),
    .strobe_low(strobe_low));

  function automatic logic [32:0] scl(logic [31:0] x, logic [15:0] g);
    longint v;
    longint h;
    int     n;
    v = (longint'(signed'(x)) * (longint'(g[3:0]) + 64'sd16)) <<< g[7:4];
    v = v >>> 4;
    case (g[14:8])
      7'h01: n = 8;
      7'h02: n = 10;
      7'h04: n = 12;
      7'h08: n = 14;
      7'h10: n = 16;
      7'h20: n = 20;
      7'h40: n = 24;
      default: n = 0;
    endcase
    if (n != 0) begin
      h = 64'sd1 <<< (31 - n);
      v = (v + h) & ~((h <<< 1) - 1);
    end
    // Saturation judged after rounding, so a round-up past full scale flags
    if (v > 64'sd2147483647 || v < -64'sd2147483648) begin
      return {1'b1, (v < 0) ? 32'h8000_0000 : 32'h7fff_ffff};
    end
    return {1'b0, v[31:0]};
  endfunction

  task automatic cmp_reg(logic [15:0] g, logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp_word(logic [33:0] g, logic [33:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic run(logic [7:0] f, logic [15:0] g);
    logic [31:0] a[6];
    logic [31:0] b[6];
    logic [32:0] sa;
    logic [32:0] sb;
    logic [31:0] w;
    logic        p;
    int          gap;
    gap = (f[5:4] == 2'h3 || f[1:0] == 2'h3) ? 4 : (f[5:4] == 2'h1 || f[1:0] == 2'h2) ? 2 : 1;
    wr(4'h6, g);
    wr(4'h7, {8'h00, f});
    // Idle level follows the format captured with a sample, two edges later
    @(posedge clk);
    sink_u.got.delete();
    exp_q.delete();
    for (int i = 0; i < 6; i++) begin
      a[i] = 32'($signed($urandom) >>> ((g == 16'h0) ? 2 : $urandom % 28));
      b[i] = 32'($signed($urandom) >>> ((g == 16'h0) ? 2 : $urandom % 28));
    end
    if (g == 16'h0050) begin
      a[0] = 32'hfc00_0000;
      b[0] = 32'h03ff_8000;
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      path_result <= {a[i], b[i]};
      result_valid <= 1'b1;
      if (i == 0) begin
        fork
          begin
            repeat (2) @(posedge clk);
            strobe_low <= f[7];
          end
        join_none
      end
      repeat (gap - 1) begin
        @(posedge clk);
        result_valid <= 1'b0;
      end
    end
    @(posedge clk);
    result_valid <= 1'b0;
    repeat (7) @(posedge clk);
    #1;
    // Even/odd phase is free-running, so take it from the first word
    p = (f[1:0] != 2'h0 && sink_u.got.size() > 0) && (sink_u.got[0][33:18] !== a[0][31:16]);
    for (int i = 0; i < 6; i++) begin
      sa = scl(a[i], g);
      sb = scl(b[i], g);
      ev_exp = ev_exp | {sb[32], sa[32]};
      if (f[1:0] != 2'h0 && (p ^ i[0])) sa[31:0] = -sa[31:0];
      else if (f[1:0] != 2'h0) sb[31:0] = -sb[31:0];
      w = (f[6] | f[2]) ? sa[31:0] + sb[31:0] : sb[31:0];
      if (f[5:4] != 2'h0) begin
        exp_q.push_back({sa[31:16], 16'h0000, 2'b00});
        exp_q.push_back({sb[31:16], 16'h0000, 2'b00});
      end else if (f[3]) exp_q.push_back({w[31:16], w[15:8], 8'h00, 2'b00});
      else exp_q.push_back({sa[31:16], w[31:16], sa[32], sb[32]});
    end
    cmp_reg(16'(sink_u.got.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) cmp_word((i < sink_u.got.size()) ? sink_u.got[i] : {34{1'bx}}, exp_q[i]);
    cmp_reg({15'h0, valid_strobe}, {15'h0, f[7]});
    $display("test format %h gain %h done", f, g);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    void'($urandom(32022));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int k = 0; k < 16; k++) begin
      rd(4'(k), rv);
      cmp_reg(rv, 16'h0000);
    end
    wr(4'h6, 16'hffff);
    wr(4'h7, 16'hffff);
    wr(4'h3, 16'hffff);
    rd(4'h6, rv);
    cmp_reg(rv, 16'h7fff);
    rd(4'h7, rv);
    cmp_reg(rv, 16'h00ff);
    rd(4'h3, rv);
    cmp_reg(rv, 16'h0000);
    $display("test registers done");
    run(8'h00, 16'h0050);
    for (int k = 0; k < 24; k++) begin
      run(8'h00, {1'b0, rnd_codes[$urandom % 8], 8'($urandom)});
    end
    foreach (fmts[k]) run(fmts[k], 16'h0000);
    rd(4'hd, rv);
    ev_exp = 2'h0;
    wr(4'he, 16'h0001);
    run(8'h00, 16'h00f0);
    cmp_reg({15'h0, irq}, {15'h0, ev_exp[0]});
    rd(4'hd, rv);
    cmp_reg(rv, {14'h0, ev_exp});
    repeat (2) @(posedge clk);
    #1 cmp_reg({15'h0, irq}, 16'h0000);
    rd(4'hd, rv);
    cmp_reg(rv, 16'h0000);
    cmp_reg(16'(sink_u.stray), 16'h0000);
    $display("test interrupt done");
    print_verdict();
  end
endmodule

`default_nettype wire
